// ### bench/hdlc_status_irq_rx_fifo_regs_bench.sv
// Self-checking bench for the HDLC event, mask, receive info and data registers.
// Assumes hsirf_host as processor; line, HDLC and transmit inputs driven here.
`default_nettype none
module hdlc_status_irq_rx_fifo_regs_bench
   import hsirf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TIMEOUT_CYCLES = 20000;
   typedef struct packed {
      logic [6:0] level;
      logic [7:0] exp;
   } hsirf_row_t;
   localparam hsirf_row_t ROWS [0:4] = '{'{7'h00, 8'h06}, '{7'h1F, 8'h06},
      '{7'h20, 8'h02}, '{7'h3F, 8'h02}, '{7'h40, 8'h00}};
   localparam logic [7:0] FRM_DATA [0:2] = '{8'h81, 8'h3C, 8'hE7};
   localparam logic [7:0] FRM_INFO [0:2] = '{8'h00, 8'h06, 8'h08};
   logic       mclk, reset_n, wr, rd, int_n;
   logic [7:0] addr, wdata, rdata, byte_data, got;
   logic       line_pos, line_neg, ext_sel, hdlc_bit, byte_wr, crc_ok;
   logic [2:0] byte_flags;
   logic [3:0] pulses;
   logic [6:0] tx_level;
   int         mismatches, num_checks, cycles;
   // ***************
   // Design and host
   // ***************
   hsirf_regs i_hsirf_regs (.MCLK(mclk), .RESET_N(reset_n), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .INT_N(int_n),
      .RX_LINE_POS(line_pos), .RX_LINE_NEG(line_neg), .LINE_SAMPLE(pulses[0]),
      .EXT_CARRIER_LOSS_SEL(ext_sel), .RX_HDLC_BIT(hdlc_bit),
      .RX_HDLC_BIT_VALID(pulses[1]), .RX_BYTE_WR(byte_wr), .RX_BYTE_DATA(byte_data),
      .RX_BYTE_FIRST(byte_flags[2]), .RX_BYTE_LAST(byte_flags[1]),
      .RX_BYTE_GOOD(byte_flags[0]), .RX_FRAME_DONE(pulses[3]), .RX_FRAME_CRC_OK(crc_ok),
      .TX_FIFO_LEVEL(tx_level), .TX_MSG_END(pulses[2]));
   hsirf_host i_hsirf_host (.clk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata));
   // ***************
   // Helpers
   // ***************
   always #4 mclk = ~mclk;
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic push(input logic [2:0] flg, input logic [7:0] d);
      @(posedge mclk);
      {byte_wr, byte_flags, byte_data} <= {1'b1, flg, d};
      @(posedge mclk);
      byte_wr <= 1'b0;
   endtask
   task automatic pulse(input logic [3:0] p);
      @(posedge mclk);
      pulses <= p;
      @(posedge mclk);
      pulses <= 4'h0;
   endtask
   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic done_test(input string n);
      $display("TEST %s finished", n);
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Hang guard, sized well above the longest test sequence
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT_CYCLES) begin
         mismatches++;
         final_report();
      end
   end
   // ***************
   // Tests
   // ***************
   initial begin
      {mclk, reset_n, line_pos, line_neg, ext_sel, hdlc_bit} = 6'b001100;
      {byte_wr, byte_flags, byte_data, crc_ok, pulses, tx_level} = '0;
      {mismatches, num_checks, cycles} = '0;
      repeat (2) @(posedge mclk);
      #1 chk8("rdata in reset", REG_RESET_VAL, rdata);
      chk1("int_n in reset", INT_N_RESET_VAL, int_n);
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      i_hsirf_host.read(HSIRF_ADDR_MASK, got);
      chk8("mask after reset", 8'h00, got);
      i_hsirf_host.read(8'hB5, got);
      chk8("unmapped read", 8'h00, got);
      done_test("reset");
      // Transmit level table, mask closed so the interrupt stays high
      for (int i = 0; i < 5; i++) begin
         tx_level <= ROWS[i].level;
         i_hsirf_host.status(HSIRF_ADDR_EVENT, 8'h00, got);
         chk8("tx live bits", ROWS[i].exp, got);
         chk1("int_n masked", 1'b1, int_n);
      end
      done_test("tx table");
      tx_level <= 7'h0A;
      i_hsirf_host.write(HSIRF_ADDR_MASK, 8'h02);
      settle();
      chk1("int_n live unmasked", 1'b0, int_n);
      i_hsirf_host.write(HSIRF_ADDR_MASK, 8'h01);
      settle();
      chk1("int_n other bit masked", 1'b1, int_n);
      i_hsirf_host.read(HSIRF_ADDR_MASK, got);
      chk8("mask readback", 8'h01, got);
      done_test("interrupt mask");
      tx_level <= 7'h40;
      crc_ok <= 1'b1;
      i_hsirf_host.write(HSIRF_ADDR_MASK, 8'h20);
      push(3'b100, FRM_DATA[0]);
      settle();
      chk1("int_n packet start", 1'b0, int_n);
      push(3'b000, FRM_DATA[1]);
      push(3'b011, FRM_DATA[2]);
      pulse(4'b1000);
      pulse(4'b0100);
      i_hsirf_host.status(HSIRF_ADDR_EVENT, 8'h61, got);
      chk8("frame events", 8'h69, got);
      settle();
      chk1("int_n released", 1'b1, int_n);
      i_hsirf_host.status(HSIRF_ADDR_INFO, 8'hF0, got);
      chk8("info first head", 8'h11, got);
      for (int i = 0; i < 3; i++) begin
         i_hsirf_host.read(HSIRF_ADDR_DATA, got);
         chk8("frame byte", FRM_DATA[i], got);
         i_hsirf_host.status(HSIRF_ADDR_INFO, 8'hF0, got);
         chk8("info after pop", FRM_INFO[i], got);
      end
      i_hsirf_host.status(HSIRF_ADDR_EVENT, 8'h61, got);
      chk8("events cleared", 8'h00, got);
      done_test("good frame");
      crc_ok <= 1'b0;
      pulse(4'b1000);
      hdlc_bit <= 1'b1;
      repeat (6) pulse(4'b0010);
      i_hsirf_host.status(HSIRF_ADDR_INFO, 8'hF0, got);
      chk8("crc error, six ones", 8'h48, got);
      pulse(4'b0010);
      for (int i = 0; i < 32; i++)
         push(3'b000, 8'(i));
      i_hsirf_host.status(HSIRF_ADDR_EVENT, 8'h40, got);
      chk8("at half, packet end", 8'h48, got);
      push(3'b000, 8'h20);
      i_hsirf_host.status(HSIRF_ADDR_EVENT, 8'h00, got);
      chk8("past half, held bit", 8'h58, got);
      i_hsirf_host.status(HSIRF_ADDR_EVENT, 8'h40, got);
      chk8("past half, refreshed", 8'h18, got);
      for (int i = 33; i < 64; i++)
         push(3'b000, 8'(i));
      push(3'b000, 8'hFF);
      i_hsirf_host.status(HSIRF_ADDR_INFO, 8'hF0, got);
      chk8("abort and overrun", 8'hA0, got);
      for (int i = 0; i < 64; i++) begin
         i_hsirf_host.read(HSIRF_ADDR_DATA, got);
         chk8("drain byte", 8'(i), got);
      end
      i_hsirf_host.status(HSIRF_ADDR_INFO, 8'hF0, got);
      chk8("drained", 8'h08, got);
      done_test("errors and full store");
      {line_pos, line_neg} <= 2'b00;
      settle();
      for (int k = 0; k < 2; k++) begin
         ext_sel <= k[0];
         repeat (k ? 2047 : 254) pulse(4'b0001);
         i_hsirf_host.status(HSIRF_ADDR_EVENT, 8'h00, got);
         chk1("carrier before count", 1'b0, got[EV_CARRIER_LOSS]);
         pulse(4'b0001);
         i_hsirf_host.status(HSIRF_ADDR_EVENT, 8'h00, got);
         chk1("carrier at count", 1'b1, got[EV_CARRIER_LOSS]);
         line_pos <= 1'b1;
         settle();
         pulse(4'b0001);
         i_hsirf_host.status(HSIRF_ADDR_EVENT, 8'h00, got);
         chk1("carrier back", 1'b0, got[EV_CARRIER_LOSS]);
         line_pos <= 1'b0;
         settle();
      end
      done_test("carrier loss");
      final_report();
   end
endmodule
`default_nettype wire

// ### bench/hsirf_host.sv
// Processor model on the parallel register port of the HDLC register bank.
// Assumes same-clock strobes and one access at a time, begun after reset.
`default_nettype none
module hsirf_host (
   input  wire logic       clk,
   output var  logic [7:0] addr,
   output var  logic [7:0] wdata,
   output var  logic       wr,
   output var  logic       rd,
   input  wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      // Released bus must not keep showing the last byte
      wdata <= ~d;
   endtask
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Mask byte first, read on the very next edge, so only selected latched bits refresh
   task automatic status(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= m;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~m;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
endmodule
`default_nettype wire

// ### verilog/hsirf_fifo_if.sv
// Connection between the register bank and its receive byte store.
// Assumes both ends sit on the same clock.
`default_nettype none
interface hsirf_fifo_if #(
   parameter int EW = 11,
   parameter int AW = 6
);
   logic          push;
   logic [EW-1:0] wdata;
   logic          pop;
   logic [EW-1:0] head;
   logic [AW:0]   count;
   logic          full;
   logic          empty;
   modport store (input push, input wdata, input pop,
                  output head, output count, output full, output empty);
   modport ctrl  (output push, output wdata, output pop,
                  input head, input count, input full, input empty);
endinterface
`default_nettype wire

// ### verilog/hsirf_pkg.sv
// Constants shared by the HDLC status, mask and receive FIFO register bank.
// Assumes one 125 MHz clock (MCLK) for every file that imports it.
`default_nettype none
package hsirf_pkg;
   // ***************
   // Register offsets
   // ***************
   localparam logic [7:0] HSIRF_ADDR_EVENT = 8'hB1;
   localparam logic [7:0] HSIRF_ADDR_MASK  = 8'hB2;
   localparam logic [7:0] HSIRF_ADDR_INFO  = 8'hB3;
   localparam logic [7:0] HSIRF_ADDR_DATA  = 8'hB4;
   // ***************
   // Event register fields
   // ***************
   localparam int EV_CARRIER_LOSS = 7;
   localparam int EV_PKT_END      = 6;
   localparam int EV_PKT_START    = 5;
   localparam int EV_RX_HALF      = 4;
   localparam int EV_RX_NOT_EMPTY = 3;
   localparam int EV_TX_HALF      = 2;
   localparam int EV_TX_NOT_FULL  = 1;
   localparam int EV_TX_MSG_END   = 0;
   localparam logic [7:0] EV_LATCHED_BITS = 8'h61;
   // ***************
   // Receive info register fields
   // ***************
   localparam int INFO_ABORT   = 7;
   localparam int INFO_CRC_ERR = 6;
   localparam int INFO_OVERRUN = 5;
   localparam int INFO_VALID   = 4;
   localparam int INFO_EMPTY   = 3;
   localparam int INFO_GOOD    = 2;
   localparam int INFO_CLOSING = 1;
   localparam int INFO_OPENING = 0;
   localparam logic [7:0] INFO_LATCHED_BITS = 8'hF0;
   // ***************
   // Reset values and counts
   // ***************
   localparam logic [7:0]  REG_RESET_VAL   = 8'h00;
   localparam logic        INT_N_RESET_VAL = 1'b1;
   localparam int          FIFO_DEPTH_DEF  = 64;
   localparam logic [11:0] CL_SHORT_COUNT  = 12'h0FF;
   localparam logic [11:0] CL_LONG_COUNT   = 12'h800;
   localparam logic [2:0]  ABORT_ONES      = 3'h7;
   // Entry marker positions above the data byte
   localparam int ENT_GOOD    = 10;
   localparam int ENT_CLOSING = 9;
   localparam int ENT_OPENING = 8;
endpackage
`default_nettype wire

// ### verilog/hsirf_regs.sv
// HDLC event, interrupt mask, receive info and receive data registers.
// Assumes host port and HDLC logic share MCLK; line inputs are asynchronous.
`default_nettype none
// What this block does
// - Carrier loss after 255 zero samples on both line inputs, 2048 if extended.
// - Packet end on valid finish, CRC error, overrun or abort.
// - Packet start when an opening byte is recognised.
// - Receive half full while the 64-byte store holds more than half.
// - Receive not empty while any byte waits in the store.
// - Transmit half empty while the transmit store holds under half.
// - Transmit not full while the transmit store has room.
// - Message end once the transmitter finishes a whole message.
// - Packet end, start and message end latch until read; others do not.
// - One mask bit per event bit; one passes, zero blocks.
// - Interrupt low on an unmasked event, released once read and nothing pending.
// - Written ones refresh and clear latched bits; zeros hold; real-time untouched.
// - Abort flag on seven or more consecutive ones.
// - CRC error flag when the frame check fails.
// - Overrun flag on a store attempt into a full store.
// - Valid message flag once a complete frame passes its check.
// - Empty flag is live, high exactly while the store is empty.
// - Packet good when head byte ends a clean frame.
// - Closing byte when head byte ends any frame.
// - Opening byte when head byte starts a frame.
// - Abort, CRC error, overrun and valid flags latch until read.
// - Data port shows the head byte, bit 7 most significant.
module hsirf_regs
   import hsirf_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
   parameter int FIFO_AW    = 6
) (
   input  wire logic                MCLK,
   input  wire logic                RESET_N,
   input  wire logic [7:0]          REG_ADDR,
   input  wire logic [7:0]          REG_WDATA,
   input  wire logic                REG_WR,
   input  wire logic                REG_RD,
   output var  logic [7:0]          REG_RDATA,
   output var  logic                INT_N,
   input  wire logic                RX_LINE_POS,
   input  wire logic                RX_LINE_NEG,
   input  wire logic                LINE_SAMPLE,
   input  wire logic                EXT_CARRIER_LOSS_SEL,
   input  wire logic                RX_HDLC_BIT,
   input  wire logic                RX_HDLC_BIT_VALID,
   input  wire logic                RX_BYTE_WR,
   input  wire logic [7:0]          RX_BYTE_DATA,
   input  wire logic                RX_BYTE_FIRST,
   input  wire logic                RX_BYTE_LAST,
   input  wire logic                RX_BYTE_GOOD,
   input  wire logic                RX_FRAME_DONE,
   input  wire logic                RX_FRAME_CRC_OK,
   input  wire logic [FIFO_AW:0]    TX_FIFO_LEVEL,
   input  wire logic                TX_MSG_END
);
   localparam logic [FIFO_AW:0] HALF_LEVEL = (FIFO_AW+1)'(FIFO_DEPTH / 2);
   localparam logic [FIFO_AW:0] FULL_LEVEL = (FIFO_AW+1)'(FIFO_DEPTH);

   hsirf_fifo_if #(.EW(11), .AW(FIFO_AW)) rxf ();

   hsirf_rx_fifo #(.DEPTH(FIFO_DEPTH), .AW(FIFO_AW), .EW(11)) u_rx_fifo (
      .clk   (MCLK),
      .rst_n (RESET_N),
      .f     (rxf.store)
   );

   // ***************
   // Line input synchronisers and carrier loss
   // ***************
   logic        pos_s1_ff;
   logic        pos_s2_ff;
   logic        neg_s1_ff;
   logic        neg_s2_ff;
   logic [11:0] zero_cnt_ff;
   logic [11:0] cl_limit;
   logic        carrier_loss_ff;

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pos_s1_ff <= 1'b0;
         pos_s2_ff <= 1'b0;
         neg_s1_ff <= 1'b0;
         neg_s2_ff <= 1'b0;
      end else begin
         pos_s1_ff <= RX_LINE_POS;
         pos_s2_ff <= pos_s1_ff;
         neg_s1_ff <= RX_LINE_NEG;
         neg_s2_ff <= neg_s1_ff;
      end
   end

   assign cl_limit = EXT_CARRIER_LOSS_SEL ? CL_LONG_COUNT : CL_SHORT_COUNT;

   // Counter saturates at the limit so long outages cannot wrap
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         zero_cnt_ff     <= '0;
         carrier_loss_ff <= 1'b0;
      end else if (LINE_SAMPLE) begin
         if (pos_s2_ff || neg_s2_ff) begin
            zero_cnt_ff     <= '0;
            carrier_loss_ff <= 1'b0;
         end else if (zero_cnt_ff < cl_limit) begin
            zero_cnt_ff     <= 12'(zero_cnt_ff + 1'b1);
            carrier_loss_ff <= (12'(zero_cnt_ff + 1'b1) >= cl_limit);
         end
      end
   end

   // ***************
   // Abort detection on the receive bit stream
   // ***************
   logic [2:0] ones_cnt_ff;
   logic       abort_hit;

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ones_cnt_ff <= '0;
      end else if (RX_HDLC_BIT_VALID) begin
         if (!RX_HDLC_BIT) begin
            ones_cnt_ff <= '0;
         end else if (ones_cnt_ff != ABORT_ONES) begin
            ones_cnt_ff <= 3'(ones_cnt_ff + 1'b1);
         end
      end
   end

   assign abort_hit = RX_HDLC_BIT_VALID && RX_HDLC_BIT &&
                      (ones_cnt_ff >= 3'(ABORT_ONES - 1'b1));

   // ***************
   // Receive store write and read sides
   // ***************
   logic host_wr_event;
   logic host_wr_info;
   logic host_rd_data;
   logic overrun_hit;

   assign host_wr_event = REG_WR && (REG_ADDR == HSIRF_ADDR_EVENT);
   assign host_wr_info  = REG_WR && (REG_ADDR == HSIRF_ADDR_INFO);
   assign host_rd_data  = REG_RD && (REG_ADDR == HSIRF_ADDR_DATA);
   assign overrun_hit   = RX_BYTE_WR && rxf.full;
   assign rxf.push      = RX_BYTE_WR;
   assign rxf.wdata     = {RX_BYTE_GOOD && RX_BYTE_LAST, RX_BYTE_LAST, RX_BYTE_FIRST,
                           RX_BYTE_DATA};
   assign rxf.pop       = host_rd_data;

   // ***************
   // Event sources
   // ***************
   logic [7:0] ev_set;
   logic [7:0] ev_live;
   logic [7:0] info_set;
   logic       pkt_start_hit;
   logic       pkt_end_hit;

   assign pkt_start_hit = RX_BYTE_WR && RX_BYTE_FIRST && !rxf.full;
   assign pkt_end_hit   = RX_FRAME_DONE || overrun_hit || abort_hit;

   always_comb begin
      ev_set                  = '0;
      ev_set[EV_PKT_END]      = pkt_end_hit;
      ev_set[EV_PKT_START]    = pkt_start_hit;
      ev_set[EV_TX_MSG_END]   = TX_MSG_END;
      ev_live                     = '0;
      ev_live[EV_CARRIER_LOSS]    = carrier_loss_ff;
      ev_live[EV_RX_HALF]         = (rxf.count > HALF_LEVEL);
      ev_live[EV_RX_NOT_EMPTY]    = !rxf.empty;
      ev_live[EV_TX_HALF]         = (TX_FIFO_LEVEL < HALF_LEVEL);
      ev_live[EV_TX_NOT_FULL]     = (TX_FIFO_LEVEL < FULL_LEVEL);
      info_set                = '0;
      info_set[INFO_ABORT]    = abort_hit;
      info_set[INFO_CRC_ERR]  = RX_FRAME_DONE && !RX_FRAME_CRC_OK;
      info_set[INFO_OVERRUN]  = overrun_hit;
      info_set[INFO_VALID]    = RX_FRAME_DONE && RX_FRAME_CRC_OK;
   end

   // ***************
   // Latched bits, snapshots and mask
   // ***************
   logic [7:0] ev_sticky_ff;
   logic [7:0] ev_snap_ff;
   logic [7:0] info_sticky_ff;
   logic [7:0] info_snap_ff;
   logic [7:0] mask_ff;
   logic [7:0] ev_sel;
   logic [7:0] info_sel;

   assign ev_sel   = host_wr_event ? (REG_WDATA & EV_LATCHED_BITS) : '0;
   assign info_sel = host_wr_info ? (REG_WDATA & INFO_LATCHED_BITS) : '0;

   // New events win over a clear in the same cycle
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ev_sticky_ff   <= REG_RESET_VAL;
         info_sticky_ff <= REG_RESET_VAL;
      end else begin
         ev_sticky_ff   <= (ev_sticky_ff & ~ev_sel) | ev_set;
         info_sticky_ff <= (info_sticky_ff & ~info_sel) | info_set;
      end
   end

   // Snapshot fixes what the following read returns; unselected bits hold
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ev_snap_ff   <= REG_RESET_VAL;
         info_snap_ff <= REG_RESET_VAL;
      end else begin
         ev_snap_ff   <= (ev_snap_ff & ~ev_sel) | (ev_sticky_ff & ev_sel);
         info_snap_ff <= (info_snap_ff & ~info_sel) | (info_sticky_ff & info_sel);
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mask_ff <= REG_RESET_VAL;
      end else if (REG_WR && (REG_ADDR == HSIRF_ADDR_MASK)) begin
         mask_ff <= REG_WDATA;
      end
   end

   // ***************
   // Interrupt output
   // ***************
   logic [7:0] irq_src;

   // Real-time bits keep the line low until the host masks them
   assign irq_src = (ev_sticky_ff & EV_LATCHED_BITS) | ev_live;

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         INT_N <= INT_N_RESET_VAL;
      end else begin
         INT_N <= ~|(irq_src & mask_ff);
      end
   end

   // ***************
   // Read data
   // ***************
   logic [7:0] info_live;
   logic       head_ok;

   assign head_ok = !rxf.empty;

   always_comb begin
      info_live               = '0;
      info_live[INFO_EMPTY]   = rxf.empty;
      info_live[INFO_GOOD]    = head_ok && rxf.head[ENT_GOOD];
      info_live[INFO_CLOSING] = head_ok && rxf.head[ENT_CLOSING];
      info_live[INFO_OPENING] = head_ok && rxf.head[ENT_OPENING];
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_RDATA <= REG_RESET_VAL;
      end else if (REG_RD) begin
         case (REG_ADDR)
            HSIRF_ADDR_EVENT: REG_RDATA <= (ev_snap_ff & EV_LATCHED_BITS) | ev_live;
            HSIRF_ADDR_MASK:  REG_RDATA <= mask_ff;
            HSIRF_ADDR_INFO:  REG_RDATA <= (info_snap_ff & INFO_LATCHED_BITS) | info_live;
            HSIRF_ADDR_DATA:  REG_RDATA <= rxf.head[7:0];
            default:          REG_RDATA <= REG_RESET_VAL;
         endcase
      end
   end

   // ***************
   // Checks
   // ***************
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   sequence s_zero_run_short;
      LINE_SAMPLE && !EXT_CARRIER_LOSS_SEL && !pos_s2_ff && !neg_s2_ff &&
      (zero_cnt_ff == 12'h0FE);
   endsequence

   sequence s_seventh_one;
      RX_HDLC_BIT_VALID && RX_HDLC_BIT && (ones_cnt_ff == 3'h6);
   endsequence

   sequence s_mask_then_read_event(int b);
      host_wr_event && REG_WDATA[b] ##1 REG_RD && (REG_ADDR == HSIRF_ADDR_EVENT);
   endsequence

   AST_CL_SHORT: assert property (s_zero_run_short |=> carrier_loss_ff)
      else $error("carrier loss not set after short zero run");
   AST_PKT_END: assert property (RX_FRAME_DONE |=> ev_sticky_ff[EV_PKT_END])
      else $error("packet end not latched");
   AST_PKT_START: assert property (pkt_start_hit |=> ev_sticky_ff[EV_PKT_START])
      else $error("packet start not latched");
   AST_ABORT: assert property (s_seventh_one |=> info_sticky_ff[INFO_ABORT])
      else $error("abort not flagged after seven ones");
   AST_OVERRUN: assert property (RX_BYTE_WR && rxf.full && !host_rd_data
                                 |=> info_sticky_ff[INFO_OVERRUN] && $stable(rxf.count))
      else $error("overrun not flagged or store changed");
   AST_INT_LOW: assert property (|(ev_set & mask_ff) && !(REG_WR && (REG_ADDR == HSIRF_ADDR_MASK))
                                 |=> ##1 !INT_N)
      else $error("unmasked event did not pull interrupt low");
   AST_INT_MASKED: assert property ((mask_ff == 8'h00) ##1 (mask_ff == 8'h00) |-> INT_N)
      else $error("interrupt low with all events masked");
   AST_HOLD_ZERO: assert property (host_wr_event && !REG_WDATA[EV_PKT_END]
                                   |=> $stable(ev_snap_ff[EV_PKT_END]))
      else $error("unselected snapshot bit changed");
   AST_READ_CLEARS: assert property (s_mask_then_read_event(EV_TX_MSG_END) ##0 !$past(TX_MSG_END)
                                     |-> !ev_sticky_ff[EV_TX_MSG_END])
      else $error("latched message end not cleared by selection");
   AST_EMPTY_LIVE: assert property (REG_RD && (REG_ADDR == HSIRF_ADDR_INFO)
                                    |=> REG_RDATA[INFO_EMPTY] == $past(rxf.empty))
      else $error("empty flag does not follow store");
   AST_POP: assert property (host_rd_data && !rxf.empty && !RX_BYTE_WR
                             |=> rxf.count == 7'($past(rxf.count) - 1'b1))
      else $error("data read did not pop one byte");
   AST_DATA_OUT: assert property (host_rd_data |=> REG_RDATA == $past(rxf.head[7:0]))
      else $error("data port does not show head byte");
endmodule
`default_nettype wire

// ### verilog/hsirf_rx_fifo.sv
// Receive byte store: data byte plus three frame markers per entry.
// Pushes into a full store are dropped; head entry comes from a register.
`default_nettype none
module hsirf_rx_fifo
   import hsirf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH_DEF,
   parameter int AW    = 6,
   parameter int EW    = 11
) (
   input wire logic       clk,
   input wire logic       rst_n,
   hsirf_fifo_if.store    f
);
   logic [EW-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW-1:0] nxt_rd_ptr;
   logic [AW:0]   count_ff;
   logic [EW-1:0] head_ff;
   logic          do_push;
   logic          do_pop;

   // Full only at the true depth; an AW-bit cast of DEPTH would wrap to zero
   assign f.full    = (count_ff == (AW+1)'(DEPTH));
   assign f.empty   = (count_ff == '0);
   assign f.count   = count_ff;
   assign f.head    = head_ff;
   assign do_push   = f.push && !f.full;
   assign do_pop    = f.pop && !f.empty;
   assign nxt_rd_ptr = do_pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_ff[wr_ptr_ff] <= f.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
         end
         rd_ptr_ff <= nxt_rd_ptr;
         if (do_push && !do_pop) begin
            count_ff <= (AW+1)'(count_ff + 1'b1);
         end else if (do_pop && !do_push) begin
            count_ff <= (AW+1)'(count_ff - 1'b1);
         end
      end
   end

   // Bypass so a byte written into an empty store is the head next cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         head_ff <= '0;
      end else if (do_push && (wr_ptr_ff == nxt_rd_ptr)) begin
         head_ff <= f.wdata;
      end else begin
         head_ff <= mem_ff[nxt_rd_ptr];
      end
   end
endmodule
`default_nettype wire
